// ---- pkg/dma_cto_pkg.sv ----
// constants, types and timeout table of the dma completion timeout registers
package dma_cto_pkg;
  // ***************
  // register map
  // ***************
  localparam logic [7:0] CAP2_OFF = 8'h64;
  localparam logic [7:0] CTL2_OFF = 8'h68;
  localparam logic [7:0] STAT_OFF = 8'hF0;
  // capabilities two fields and fixed values
  localparam int RANGES_LSB = 0;
  localparam int DIS_SUP_BIT = 4;
  localparam int ARI_FWD_BIT = 5;
  localparam int ATOM_RT_BIT = 6;
  localparam int ATOM32_BIT = 7;
  localparam int ATOM64_BIT = 8;
  localparam int CAS128_BIT = 9;
  localparam int NO_RO_BIT = 10;
  localparam int LTR_BIT = 11;
  localparam int TPH_LSB = 12;
  localparam int EXT_FMT_BIT = 20;
  localparam int PREFIX_BIT = 21;
  localparam logic [3:0] RANGES_DEF = 4'hF;
  localparam logic DIS_SUP_DEF = 1'b1;
  localparam logic NOT_SUP = 1'b0;
  localparam logic NO_RO_DEF = 1'b1;
  localparam logic [1:0] TPH_DEF = 2'h0;
  // control two fields
  localparam int TO_VAL_LSB = 0;
  localparam int TO_DIS_BIT = 4;
  localparam logic [3:0] TO_VAL_RST = 4'h0;
  localparam logic TO_DIS_RST = 1'b0;
  // status fields
  localparam int ST_CNT_LSB = 0;
  localparam int ST_RUN_BIT = 8;
  localparam int ST_SEEN_BIT = 9;
  localparam logic [7:0] OUTST_MAX = 8'hFF;
  // ***************
  // timing
  // ***************
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 1;
  localparam logic [7:0] TICK_CYC = 8'(CLK_MHZ * TICK_US);
  localparam int TO0_US = 50;
  localparam int TO1_US = 100;
  localparam int TO2_MS = 10;
  localparam int TO5_MS = 55;
  localparam int TO6_MS = 210;
  localparam int TO9_MS = 900;
  localparam int TOA_MS = 3500;
  localparam int TOD_S = 13;
  localparam int TOE_S = 34;

  typedef enum logic [0:0] {TMR_IDLE, TMR_RUN} tmr_state_type;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [3:0] to_val;
    logic to_dis;
    logic seen;
    logic fire;
    logic [7:0] outst;
    logic [25:0] elapsed;
    logic [7:0] tick_cnt;
    tmr_state_type st;
  } state_type;

  // wait limit in ticks; reserved codes fall back to the shortest wait
  function automatic logic [25:0] limit_ticks(input logic [3:0] code);
    case (code)
      4'h1: limit_ticks = 26'(TO1_US / TICK_US);
      4'h2: limit_ticks = 26'(TO2_MS * 1000 / TICK_US);
      4'h5: limit_ticks = 26'(TO5_MS * 1000 / TICK_US);
      4'h6: limit_ticks = 26'(TO6_MS * 1000 / TICK_US);
      4'h9: limit_ticks = 26'(TO9_MS * 1000 / TICK_US);
      4'hA: limit_ticks = 26'(TOA_MS * 1000 / TICK_US);
      4'hD: limit_ticks = 26'(TOD_S * 1000000 / TICK_US);
      4'hE: limit_ticks = 26'(TOE_S * 1000000 / TICK_US);
      default: limit_ticks = 26'(TO0_US / TICK_US);
    endcase
  endfunction
endpackage

// ---- hw/dma_cto_regs.sv ----
// completion timeout capability, control and watchdog of the dma function
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/1ps
module dma_cto_regs #(
  parameter logic [7:0] TICK_CYCLES = dma_cto_pkg::TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic req_issue_i,
  input wire logic req_done_i,
  output logic [3:0] timeout_value_o,
  output logic timeout_disable_o,
  output logic timeout_o
);
  dma_cto_pkg::state_type s_r;
  dma_cto_pkg::state_type s_nxt;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;
  logic [31:0] stat_word;
  logic req;
  logic wr_ctl;
  logic tick;
  logic [25:0] limit;
  logic due;

  // ***************
  // fixed capability word
  // ***************
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[dma_cto_pkg::RANGES_LSB +: 4] = dma_cto_pkg::RANGES_DEF;
    cap_word[dma_cto_pkg::DIS_SUP_BIT] = dma_cto_pkg::DIS_SUP_DEF;
    cap_word[dma_cto_pkg::ARI_FWD_BIT] = dma_cto_pkg::NOT_SUP;
    cap_word[dma_cto_pkg::ATOM_RT_BIT] = dma_cto_pkg::NOT_SUP;
    cap_word[dma_cto_pkg::ATOM32_BIT] = dma_cto_pkg::NOT_SUP;
    cap_word[dma_cto_pkg::ATOM64_BIT] = dma_cto_pkg::NOT_SUP;
    cap_word[dma_cto_pkg::CAS128_BIT] = dma_cto_pkg::NOT_SUP;
    cap_word[dma_cto_pkg::NO_RO_BIT] = dma_cto_pkg::NO_RO_DEF;
    cap_word[dma_cto_pkg::LTR_BIT] = dma_cto_pkg::NOT_SUP;
    cap_word[dma_cto_pkg::TPH_LSB +: 2] = dma_cto_pkg::TPH_DEF;
    cap_word[dma_cto_pkg::EXT_FMT_BIT] = dma_cto_pkg::NOT_SUP;
    cap_word[dma_cto_pkg::PREFIX_BIT] = dma_cto_pkg::NOT_SUP;
  end

  always_comb begin
    ctl_word = 32'h0000_0000;
    ctl_word[dma_cto_pkg::TO_VAL_LSB +: 4] = s_r.to_val;
    ctl_word[dma_cto_pkg::TO_DIS_BIT] = s_r.to_dis;
    stat_word = 32'h0000_0000;
    stat_word[dma_cto_pkg::ST_CNT_LSB +: 8] = s_r.outst;
    stat_word[dma_cto_pkg::ST_RUN_BIT] = (s_r.st == dma_cto_pkg::TMR_RUN);
    stat_word[dma_cto_pkg::ST_SEEN_BIT] = s_r.seen;
  end

  // ***************
  // next state
  // ***************
  always_comb begin
    s_nxt = s_r;
    req = wb_cyc_i && wb_stb_i && !s_r.ack;
    wr_ctl = req && wb_we_i && wb_sel_i[0]
      && (wb_adr_i[7:2] == dma_cto_pkg::CTL2_OFF[7:2]);
    tick = (s_r.tick_cnt == TICK_CYCLES - 8'h01);
    limit = dma_cto_pkg::limit_ticks(s_r.to_val);
    due = 1'b0;
    // bus slave: one-cycle ack, unmapped words read zero
    s_nxt.ack = req;
    s_nxt.rdat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      case (wb_adr_i[7:2])
        dma_cto_pkg::CAP2_OFF[7:2]: s_nxt.rdat = cap_word;
        dma_cto_pkg::CTL2_OFF[7:2]: s_nxt.rdat = ctl_word;
        dma_cto_pkg::STAT_OFF[7:2]: s_nxt.rdat = stat_word;
        default: s_nxt.rdat = 32'h0000_0000;
      endcase
    end
    // accepted at any time, open requests or not
    if (wr_ctl) begin
      s_nxt.to_val = wb_dat_i[dma_cto_pkg::TO_VAL_LSB +: 4];
      s_nxt.to_dis = wb_dat_i[dma_cto_pkg::TO_DIS_BIT];
    end
    // outstanding request count, saturating both ways
    if (req_issue_i && !req_done_i && s_r.outst != dma_cto_pkg::OUTST_MAX) begin
      s_nxt.outst = s_r.outst + 8'h01;
    end else if (req_done_i && !req_issue_i && s_r.outst != 8'h00) begin
      s_nxt.outst = s_r.outst - 8'h01;
    end
    // 1 us tick keeps the wait counter narrow
    s_nxt.tick_cnt = tick ? 8'h00 : s_r.tick_cnt + 8'h01;
    s_nxt.fire = 1'b0;
    case (s_r.st)
      dma_cto_pkg::TMR_IDLE: begin
        s_nxt.elapsed = 26'h000_0000;
        if (s_nxt.outst != 8'h00) begin
          s_nxt.st = dma_cto_pkg::TMR_RUN;
        end
      end
      dma_cto_pkg::TMR_RUN: begin
        if (tick) begin
          s_nxt.elapsed = s_r.elapsed + 26'h000_0001;
          due = (s_nxt.elapsed >= limit);
        end
        // a completion restarts the wait for the next oldest request
        if (req_done_i || due) begin
          s_nxt.elapsed = 26'h000_0000;
        end
        if (s_nxt.outst == 8'h00) begin
          s_nxt.st = dma_cto_pkg::TMR_IDLE;
        end
      end
      default: s_nxt.st = dma_cto_pkg::TMR_IDLE;
    endcase
    // new code counts from the change and uses the new length
    if (wr_ctl && s_nxt.to_val != s_r.to_val) begin
      s_nxt.elapsed = 26'h000_0000;
    end
    // disable written this cycle already suppresses the flag
    s_nxt.fire = due && !s_r.to_dis && !s_nxt.to_dis;
    // sticky seen bit: write one clears, a new timeout wins
    if (req && wb_we_i && wb_sel_i[1]
        && wb_adr_i[7:2] == dma_cto_pkg::STAT_OFF[7:2]
        && wb_dat_i[dma_cto_pkg::ST_SEEN_BIT]) begin
      s_nxt.seen = 1'b0;
    end
    if (s_nxt.fire) begin
      s_nxt.seen = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r.ack <= 1'b0;
      s_r.rdat <= 32'h0000_0000;
      s_r.to_val <= dma_cto_pkg::TO_VAL_RST;
      s_r.to_dis <= dma_cto_pkg::TO_DIS_RST;
      s_r.seen <= 1'b0;
      s_r.fire <= 1'b0;
      s_r.outst <= 8'h00;
      s_r.elapsed <= 26'h000_0000;
      s_r.tick_cnt <= 8'h00;
      s_r.st <= dma_cto_pkg::TMR_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdat;
  assign timeout_value_o = s_r.to_val;
  assign timeout_disable_o = s_r.to_dis;
  assign timeout_o = s_r.fire;

  // ***************
  // assertions
  // ***************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence cap_read_s;
    wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
      && wb_adr_i == dma_cto_pkg::CAP2_OFF;
  endsequence

  sequence ctl_write_s;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
      && wb_adr_i == dma_cto_pkg::CTL2_OFF;
  endsequence

  a_caps_read_value: assert property (
    cap_read_s |=> wb_ack_o && wb_dat_o[11:0] == 12'h41F)
    else $error("capability low bits wrong");

  a_caps_high_zero: assert property (
    cap_read_s |=> wb_dat_o[31:12] == 20'h0_0000)
    else $error("capability high bits not zero");

  a_ctl_write_takes: assert property (
    ctl_write_s |=> timeout_value_o == $past(wb_dat_i[3:0])
      && timeout_disable_o == $past(wb_dat_i[4]))
    else $error("control write not stored");

  a_ctl_reset_zero: assert property (
    $fell(rst_i) |-> timeout_value_o == 4'h0 && !timeout_disable_o)
    else $error("control not zero after reset");

  sequence cap_write_s;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
      && wb_adr_i == dma_cto_pkg::CAP2_OFF;
  endsequence

  sequence stat_clear_s;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[1]
      && wb_adr_i == dma_cto_pkg::STAT_OFF
      && wb_dat_i[dma_cto_pkg::ST_SEEN_BIT];
  endsequence

  sequence open_issue_s;
    req_issue_i && !req_done_i && s_r.outst != dma_cto_pkg::OUTST_MAX;
  endsequence

  sequence open_done_s;
    req_done_i && !req_issue_i && s_r.outst != 8'h00;
  endsequence

  a_decode_table: assert property (
    (s_r.to_val == 4'h0 |-> limit == 26'h000_0032)
      and (s_r.to_val == 4'h1 |-> limit == 26'h000_0064)
      and (s_r.to_val == 4'h2 |-> limit == 26'h000_2710)
      and (s_r.to_val == 4'h3 |-> limit == 26'h000_0032)
      and (s_r.to_val == 4'h5 |-> limit == 26'h000_D6D8)
      and (s_r.to_val == 4'h6 |-> limit == 26'h003_3450)
      and (s_r.to_val == 4'h9 |-> limit == 26'h00D_BBA0)
      and (s_r.to_val == 4'hA |-> limit == 26'h035_67E0)
      and (s_r.to_val == 4'hD |-> limit == 26'h0C6_5D40)
      and (s_r.to_val == 4'hE |-> limit == 26'h206_CC80))
    else $error("timeout code decoded wrong");

  a_change_restarts: assert property (
    $changed(timeout_value_o) |-> s_r.elapsed == 26'h000_0000)
    else $error("wait not restarted on code change");

  a_disable_quiet: assert property (
    timeout_disable_o |-> !timeout_o ##1 (!timeout_o || !$past(s_r.to_dis)))
    else $error("timeout flagged while disabled");

  a_fire_needs_open: assert property (
    timeout_o |-> $past(s_r.outst) != 8'h00
      && $past(s_r.st) == dma_cto_pkg::TMR_RUN
      && s_r.elapsed == 26'h000_0000)
    else $error("timeout without open request");

  a_wait_bounded: assert property (
    s_r.st == dma_cto_pkg::TMR_RUN |-> s_r.elapsed <= limit
      || $changed(s_r.to_val))
    else $error("wait ran past its limit");

  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  a_ack_follows_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");

  a_read_idle_zero: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack not zero");

  a_cap_write_ignored: assert property (
    cap_write_s |=> $stable(timeout_value_o) && $stable(timeout_disable_o))
    else $error("capability write changed control");

  a_seen_set: assert property (
    timeout_o |-> s_r.seen)
    else $error("timeout not recorded in status");

  a_seen_sticky: assert property (
    s_r.seen && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> s_r.seen)
    else $error("status seen bit lost");

  a_seen_clear: assert property (
    stat_clear_s |=> s_r.seen == timeout_o)
    else $error("status seen bit not cleared");

  a_count_up: assert property (
    open_issue_s |=> s_r.outst == $past(s_r.outst) + 8'h01)
    else $error("issued request not counted");

  a_count_down: assert property (
    open_done_s |=> s_r.outst == $past(s_r.outst) - 8'h01)
    else $error("completion not counted");

  a_count_cancel: assert property (
    req_issue_i && req_done_i |=> $stable(s_r.outst))
    else $error("issue and completion together not cancelled");

  a_run_iff_open: assert property (
    (s_r.st == dma_cto_pkg::TMR_RUN) == (s_r.outst != 8'h00))
    else $error("timer state and open count disagree");

  a_tick_in_range: assert property (
    s_r.tick_cnt < TICK_CYCLES)
    else $error("tick divider out of range");

  a_fire_on_limit: assert property (
    s_r.st == dma_cto_pkg::TMR_RUN && tick && !wb_cyc_i && !s_r.to_dis
      && s_r.elapsed + 26'h000_0001 == limit |=> timeout_o)
    else $error("timeout missed at its limit");

  a_no_early_fire: assert property (
    timeout_o |-> $past(s_r.elapsed) + 26'h000_0001 == $past(limit))
    else $error("timeout before its limit");
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the dma completion timeout registers
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); \
  end \
end
module tb_top;
  // one-cycle tick keeps the 10 ms code at 10000 cycles
  localparam logic [7:0] TICKS = 8'h01;
  localparam int LIMIT = 40000;
  logic clk, rst, cyc, stb, we, issue, done;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, dat_o;
  logic ack, td, tout;
  logic [3:0] tv;
  int errors, checks, cycles;

  dma_cto_regs #(.TICK_CYCLES(TICKS)) uut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .req_issue_i(issue),
    .req_done_i(done), .timeout_value_o(tv), .timeout_disable_o(td),
    .timeout_o(tout)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ***************
  // bus and request tasks
  // ***************
  task automatic wb_xfer(input logic w, input logic [7:0] a,
                         input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
    wb_xfer(1'b0, a, 32'h0);
    `CHK(nm, e, rdat)
  endtask

  task automatic pulse(input logic fin);
    @(posedge clk);
    if (fin) done <= 1'b1;
    else issue <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    issue <= 1'b0;
  endtask

  // request opened first, then the code rewritten under it
  task automatic timed(input logic [3:0] code, input int lim);
    int n;
    n = 0;
    pulse(1'b0);
    wb_xfer(1'b1, dma_cto_pkg::CTL2_OFF, {28'h0, code});
    while (tout !== 1'b1 && n < lim + 20) begin
      @(posedge clk);
      n++;
    end
    `CHK("timeout delay", 1'b1, (n >= lim - 2 && n <= lim + 6))
    rd_chk(dma_cto_pkg::STAT_OFF, 32'h0000_0301, "stat fired");
    pulse(1'b1);
    rd_chk(dma_cto_pkg::STAT_OFF, 32'h0000_0200, "stat idle");
    wb_xfer(1'b1, dma_cto_pkg::STAT_OFF, 32'h0000_0200);
    rd_chk(dma_cto_pkg::STAT_OFF, 32'h0, "stat cleared");
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      finish_test;
    end
  end

  // ***************
  // main sequence
  // ***************
  initial begin
    int n;
    rst = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    issue = 1'b0;
    done = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    `CHK("value out", 4'h0, tv)
    `CHK("disable out", 1'b0, td)
    // ranges F, disable supported, bit 10 set, all else zero
    rd_chk(dma_cto_pkg::CAP2_OFF, 32'h0000041F, "cap");
    wb_xfer(1'b1, dma_cto_pkg::CAP2_OFF, 32'hFFFFFFFF);
    rd_chk(dma_cto_pkg::CAP2_OFF, 32'h0000041F, "cap ro");
    rd_chk(dma_cto_pkg::CAP2_OFF, 32'h0000041F, "cap hi");
    rd_chk(dma_cto_pkg::CAP2_OFF, 32'h0000041F, "cap pfx");
    rd_chk(dma_cto_pkg::CTL2_OFF, 32'h0, "ctl reset");
    rd_chk(8'h00, 32'h0, "unmapped");
    for (int c = 0; c < 16; c++) begin
      wb_xfer(1'b1, dma_cto_pkg::CTL2_OFF, 32'(c));
      rd_chk(dma_cto_pkg::CTL2_OFF, 32'(c), "ctl code");
      `CHK("value out", 4'(c), tv)
    end
    timed(4'h0, dma_cto_pkg::TO0_US);
    timed(4'h1, dma_cto_pkg::TO1_US);
    timed(4'h2, dma_cto_pkg::TO2_MS * 1000);
    // disabled checking: an open request never times out
    wb_xfer(1'b1, dma_cto_pkg::CTL2_OFF, 32'h10);
    `CHK("disable out", 1'b1, td)
    rd_chk(dma_cto_pkg::CTL2_OFF, 32'h10, "ctl disable");
    pulse(1'b0);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      if (tout !== 1'b0) n++;
    end
    `CHK("timeouts while disabled", 0, n)
    rd_chk(dma_cto_pkg::STAT_OFF, 32'h0000_0101, "stat quiet");
    pulse(1'b1);
    // checking goes back on once the open request has drained
    wb_xfer(1'b1, dma_cto_pkg::CTL2_OFF, 32'h0);
    `CHK("disable out", 1'b0, td)
    finish_test;
  end
endmodule
